// ---- hdl/ppi_map.vh ----
/*
 * Constants of the parallel programming port: commands, action codes,
 * signature addresses, page geometry and timing.
 * Assumes inclusion by bare name from the port's design files.
 */
`ifndef PPI_MAP_VH
`define PPI_MAP_VH

// Load action codes on the two action-select pins
`define PPI_ACT_ADDR 2'h0
`define PPI_ACT_DATA 2'h1
`define PPI_ACT_CMD 2'h2
`define PPI_ACT_IDLE 2'h3

// Command bytes
`define PPI_CMD_NOP 8'h00
`define PPI_CMD_CHIP_ERASE 8'h80
`define PPI_CMD_WR_FUSE 8'h40
`define PPI_CMD_WR_LOCK 8'h20
`define PPI_CMD_WR_FLASH 8'h10
`define PPI_CMD_WR_EEPROM 8'h11
`define PPI_CMD_RD_SIG 8'h08
`define PPI_CMD_RD_FUSE_LOCK 8'h04
`define PPI_CMD_RD_FLASH 8'h02
`define PPI_CMD_RD_EEPROM 8'h03

// Signature address space
`define PPI_SIG_ADDR0 2'h0
`define PPI_SIG_ADDR1 2'h1
`define PPI_SIG_ADDR2 2'h2

// Page geometry
`define PPI_FLASH_PAGE_SMALL 32
`define PPI_FLASH_PAGE_LARGE 64
`define PPI_EE_PAGE_BYTES 4
`define PPI_EE_WORD_BITS 2

// Reset values
`define PPI_RST_BYTE 8'h00
`define PPI_RST_WORD 16'h0000
`define PPI_RST_TRIM 8'h80

// Timing: least pulse width in ns and clock period in ns
`define PPI_MIN_PULSE_NS 250
`define PPI_CLK_NS 50
`define PPI_MIN_PULSE_CYC ((`PPI_MIN_PULSE_NS + `PPI_CLK_NS - 1) / `PPI_CLK_NS)
`define PPI_BUSY_CYC 64

`endif

// ---- hdl/ppi_sync_edge.v ----
/*
 * Two-flop synchroniser for a group of pins, with rise and fall pulses.
 * Assumes inputs come asynchronously from package pins.
 */
`timescale 1ns/1ps
module ppi_sync_edge #(
	parameter WIDTH = 4
) (
	// Clock and reset
	input wire core_clk,
	input wire reset,
	// Raw pins
	input wire [WIDTH-1:0] pin_in,
	// Synchronised level and edges
	output reg [WIDTH-1:0] level_out,
	output wire [WIDTH-1:0] rise_out,
	output wire [WIDTH-1:0] fall_out
);
	reg [WIDTH-1:0] meta_reg; // First stage, read only by second
	reg [WIDTH-1:0] prev_reg; // Delayed level for edges

	// Two flip-flops then an edge history stage
	always @(posedge core_clk) begin
		if (reset) begin
			meta_reg <= {WIDTH{1'b0}};
			level_out <= {WIDTH{1'b0}};
			prev_reg <= {WIDTH{1'b0}};
		end else begin
			meta_reg <= pin_in;
			level_out <= meta_reg;
			prev_reg <= level_out;
		end
	end

	// Edge pulses from settled levels only
	assign rise_out = level_out & ~prev_reg;
	assign fall_out = ~level_out & prev_reg;
endmodule // ppi_sync_edge

// ---- hdl/ppi_port.v ----
/*
 * Parallel programming port: byte loads via a load pulse, command decode,
 * write and read strobes, page latching, busy flag, signature reads and
 * calibration copy to the RC trim register on each clock after reset.
 * Assumes pins are asynchronous and the programmer keeps pulses wide;
 * the memory arrays behind the port live here as small models.
 */
// Notes on behaviour
// R1: Signature readable in all modes despite locks
// R2: Signature bytes at addresses 0 to 2
// R3: Calibration is high byte at address 0
// R4: Reset copies calibration into trim register
// R5: Flash pages of 32 or 64 words
// R6: EEPROM pages of four bytes
// R7: Programmer pulses last at least 250 ns
// R8: Load pulse performs selected load action
// R9: Action codes address, data, command, idle
// R10: First byte select picks low/high byte
// R11: Second byte select picks second high
// R12: Strobes execute last loaded command
// R13: Ready/busy low while operation runs
// R14: Data bus driven only while read-enable low; data_oe here follows the pin three clock edges late
// R15: Programmer drives write strobe low
// R16: Page latch moves data to page buffer
// R17: Entry pattern holds four pins low
// R18: Decode erase, flash and EEPROM writes
// R19: Decode signature, flash and EEPROM reads
// R20: Decode fuse write, lock write, fuse read
// R21: Command and address persist across operations
// R22: No-op command ends page programming
// R23: Unknown command does nothing
`timescale 1ns/1ps
`include "ppi_map.vh"
module ppi_port #(
	parameter LARGE_PART = 1,
	parameter FLASH_AW = 14,
	parameter EE_AW = 10,
	parameter [7:0] SIG_BYTE0 = 8'h5a,
	parameter [7:0] SIG_BYTE1 = 8'h3c,
	parameter [7:0] SIG_BYTE2 = 8'h21,
	parameter [7:0] CAL_BYTE = 8'h7e,
	parameter BUSY_CYC = `PPI_BUSY_CYC
) (
	// Clock and reset
	input wire core_clk,
	input wire reset,
	// Programmer strobes and selects
	input wire load_pulse_pin,
	input wire pulse_action_sel0,
	input wire pulse_action_sel1,
	input wire byte_sel_first,
	input wire byte_sel_second,
	input wire page_latch_pulse,
	input wire write_n,
	input wire read_enable_n,
	// Data bus, split
	input wire [7:0] data_in,
	output reg [7:0] data_out,
	output reg data_oe,
	// Status
	output reg ready_busy_out,
	output reg [7:0] rc_trim_register,
	output reg [7:0] lock_bits_out
);
	// Signature bytes and calibration are fixed values (arbitrary here)
	localparam PAGE_WORDS = LARGE_PART ? `PPI_FLASH_PAGE_LARGE : `PPI_FLASH_PAGE_SMALL;
	localparam WB = LARGE_PART ? 6 : 5; // Word-in-page bit count
	localparam FLASH_WORDS = 1 << FLASH_AW;
	localparam EE_BYTES = 1 << EE_AW;
	// Sequencer states
	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_BUSY = 2'h1;
	localparam [1:0] ST_ERASE = 2'h2;

	// Synchronised pins
	wire [7:0] sync_level;
	wire [7:0] sync_rise;
	reg [7:0] data_meta_reg; // Bus first stage
	reg [7:0] data_sync_reg; // Bus settled

	// Loaded state
	reg [7:0] cmd_reg; // Last command
	reg [15:0] addr_reg; // Last address
	reg [15:0] data_word_reg; // Loaded data word
	reg [7:0] fuse_low_reg; // Low fuse byte
	reg [7:0] fuse_high_reg; // High fuse byte
	reg [7:0] fuse_ext_reg; // Extended fuse byte
	reg write_armed_reg; // Page session open
	reg [1:0] state_reg; // Sequencer state
	reg [15:0] busy_cnt_reg; // Programming time left
	reg [FLASH_AW-1:0] erase_idx_reg; // Erase sweep index

	// Memories and page buffers
	reg [15:0] flash_mem [0:FLASH_WORDS-1];
	reg [7:0] ee_mem [0:EE_BYTES-1];
	reg [15:0] flash_buf [0:PAGE_WORDS-1];
	reg [7:0] ee_buf [0:`PPI_EE_PAGE_BYTES-1];
	reg [PAGE_WORDS-1:0] flash_buf_valid;
	reg [`PPI_EE_PAGE_BYTES-1:0] ee_buf_valid;
	reg [7:0] read_byte; // Combinational read value
	integer i;

	// Pin order: load, sel0, sel1, bs1, bs2, page latch, write, read enable
	// Active-low strobes enter inverted, so the cleared synchroniser
	// equals their idle level and no false edge follows reset
	ppi_sync_edge #(.WIDTH(8)) u_sync (
		.core_clk(core_clk),
		.reset(reset),
		.pin_in({~read_enable_n, ~write_n, page_latch_pulse, byte_sel_second,
			byte_sel_first, pulse_action_sel1, pulse_action_sel0, load_pulse_pin}),
		.level_out(sync_level),
		.rise_out(sync_rise),
		.fall_out()
	);

	// Decoded pin levels and address fields
	wire [1:0] action = {sync_level[2], sync_level[1]};
	wire bs1 = sync_level[3];
	wire bs2 = sync_level[4];
	wire oe_low = sync_level[7]; // Read enable asserted
	wire [WB-1:0] word_in_page_bits = addr_reg[WB-1:0]; // R5
	wire [FLASH_AW-1:0] flash_addr = addr_reg[FLASH_AW-1:0];
	wire [EE_AW-1:0] eeprom_byte_addr = addr_reg[EE_AW-1:0];
	wire [`PPI_EE_WORD_BITS-1:0] ee_word = addr_reg[`PPI_EE_WORD_BITS-1:0]; // R6
	wire [FLASH_AW-WB-1:0] page_index_bits = flash_addr[FLASH_AW-1:WB]; // R5
	wire [EE_AW-3:0] ee_page = eeprom_byte_addr[EE_AW-1:2]; // R6
	wire idle = (state_reg == ST_IDLE);

	// Data bus synchroniser
	always @(posedge core_clk) begin
		if (reset) begin
			data_meta_reg <= `PPI_RST_BYTE;
			data_sync_reg <= `PPI_RST_BYTE;
		end else begin
			data_meta_reg <= data_in;
			data_sync_reg <= data_meta_reg;
		end
	end

	// Read value for the current command
	always @* begin
		read_byte = `PPI_RST_BYTE;
		case (cmd_reg) // R12
		`PPI_CMD_RD_SIG: begin // R19 R1
			if (bs1) begin
				// Calibration shares location 0, upper half
				read_byte = CAL_BYTE; // R3
			end else begin
				case (addr_reg[1:0]) // R2
				`PPI_SIG_ADDR0: read_byte = SIG_BYTE0;
				`PPI_SIG_ADDR1: read_byte = SIG_BYTE1;
				`PPI_SIG_ADDR2: read_byte = SIG_BYTE2;
				default: read_byte = `PPI_RST_BYTE;
				endcase
			end
		end
		`PPI_CMD_RD_FLASH: begin // R19 R10
			read_byte = bs1 ? flash_mem[flash_addr][15:8] : flash_mem[flash_addr][7:0];
		end
		`PPI_CMD_RD_EEPROM: begin // R19
			read_byte = ee_mem[eeprom_byte_addr];
		end
		`PPI_CMD_RD_FUSE_LOCK: begin // R20 R11
			if (bs2) begin
				read_byte = fuse_ext_reg;
			end else if (bs1) begin
				read_byte = bs2 ? fuse_ext_reg : lock_bits_out;
			end else begin
				read_byte = fuse_low_reg;
			end
			if (bs1 && bs2) begin
				read_byte = fuse_high_reg;
			end
		end
		default: begin
			read_byte = `PPI_RST_BYTE; // R23
		end
		endcase
	end

	// Loads, strobes and the busy sequencer
	always @(posedge core_clk) begin
		if (reset) begin
			cmd_reg <= `PPI_CMD_NOP;
			addr_reg <= `PPI_RST_WORD;
			data_word_reg <= `PPI_RST_WORD;
			// Fuse and lock bits start unprogrammed
			fuse_low_reg <= 8'hff;
			fuse_high_reg <= 8'hff;
			fuse_ext_reg <= 8'hff;
			lock_bits_out <= 8'hff;
			write_armed_reg <= 1'b0;
			state_reg <= ST_IDLE;
			busy_cnt_reg <= 16'h0000;
			erase_idx_reg <= {FLASH_AW{1'b0}};
			flash_buf_valid <= {PAGE_WORDS{1'b0}};
			ee_buf_valid <= {`PPI_EE_PAGE_BYTES{1'b0}};
			ready_busy_out <= 1'b1;
			rc_trim_register <= `PPI_RST_TRIM;
			data_out <= `PPI_RST_BYTE;
			data_oe <= 1'b0;
		end else begin
			// Trim always holds the stored calibration after reset
			rc_trim_register <= CAL_BYTE; // R4
			// Bus turns toward the programmer only while the synchronised read enable is asserted, three clock edges after the pin
			data_oe <= oe_low; // R14
			data_out <= oe_low ? read_byte : `PPI_RST_BYTE; // R14
			ready_busy_out <= idle; // R13
			// Load pulse action
			if (sync_rise[0] && idle) begin // R8
				case (action) // R9
				`PPI_ACT_ADDR: begin
					if (bs1) begin // R10
						addr_reg[15:8] <= data_sync_reg;
					end else begin
						addr_reg[7:0] <= data_sync_reg;
					end
				end
				`PPI_ACT_DATA: begin
					if (bs1) begin // R10
						data_word_reg[15:8] <= data_sync_reg;
					end else begin
						data_word_reg[7:0] <= data_sync_reg;
					end
				end
				`PPI_ACT_CMD: begin
					cmd_reg <= data_sync_reg; // R21
					if (data_sync_reg == `PPI_CMD_NOP) begin // R22
						write_armed_reg <= 1'b0;
						flash_buf_valid <= {PAGE_WORDS{1'b0}};
						ee_buf_valid <= {`PPI_EE_PAGE_BYTES{1'b0}};
					end else begin
						write_armed_reg <= 1'b1;
					end
				end
				default: begin
					cmd_reg <= cmd_reg; // R9
				end
				endcase
			end
			// Write strobe executes loaded command
			case (state_reg)
			ST_IDLE: begin
				// Write strobe asserted while a command is armed
				if (sync_rise[6] && write_armed_reg) begin // R12 R15
					case (cmd_reg) // R18 R20
					`PPI_CMD_CHIP_ERASE: begin
						lock_bits_out <= 8'hff;
						erase_idx_reg <= {FLASH_AW{1'b0}};
						state_reg <= ST_ERASE;
						ready_busy_out <= 1'b0;
					end
					`PPI_CMD_WR_FLASH: begin
						for (i = 0; i < PAGE_WORDS; i = i + 1) begin
							if (flash_buf_valid[i]) begin
								flash_mem[{page_index_bits, i[WB-1:0]}] <= flash_buf[i];
							end
						end
						flash_buf_valid <= {PAGE_WORDS{1'b0}};
						busy_cnt_reg <= BUSY_CYC[15:0];
						state_reg <= ST_BUSY;
						ready_busy_out <= 1'b0;
					end
					`PPI_CMD_WR_EEPROM: begin
						for (i = 0; i < `PPI_EE_PAGE_BYTES; i = i + 1) begin
							if (ee_buf_valid[i]) begin
								ee_mem[{ee_page, i[1:0]}] <= ee_buf[i];
							end
						end
						ee_buf_valid <= {`PPI_EE_PAGE_BYTES{1'b0}};
						busy_cnt_reg <= BUSY_CYC[15:0];
						state_reg <= ST_BUSY;
						ready_busy_out <= 1'b0;
					end
					`PPI_CMD_WR_FUSE: begin
						if (bs1 && bs2) begin // R11
							fuse_ext_reg <= data_word_reg[7:0];
						end else if (bs1) begin
							fuse_high_reg <= data_word_reg[7:0];
						end else begin
							fuse_low_reg <= data_word_reg[7:0];
						end
						busy_cnt_reg <= BUSY_CYC[15:0];
						state_reg <= ST_BUSY;
						ready_busy_out <= 1'b0;
					end
					`PPI_CMD_WR_LOCK: begin
						lock_bits_out <= lock_bits_out & data_word_reg[7:0];
						busy_cnt_reg <= BUSY_CYC[15:0];
						state_reg <= ST_BUSY;
						ready_busy_out <= 1'b0;
					end
					default: begin
						state_reg <= ST_IDLE; // R23
					end
					endcase
				end
			end
			ST_BUSY: begin
				// Count down the programming time
				ready_busy_out <= 1'b0; // R13
				if (busy_cnt_reg == 16'h0000) begin
					state_reg <= ST_IDLE;
					ready_busy_out <= 1'b1;
				end else begin
					busy_cnt_reg <= busy_cnt_reg - 16'h0001;
				end
			end
			ST_ERASE: begin
				// One word cleared per clock, EEPROM shares the index
				ready_busy_out <= 1'b0; // R13
				flash_mem[erase_idx_reg] <= 16'hffff;
				if (erase_idx_reg < EE_BYTES) begin
					ee_mem[erase_idx_reg[EE_AW-1:0]] <= 8'hff;
				end
				if (erase_idx_reg == FLASH_WORDS - 1) begin
					state_reg <= ST_IDLE;
					ready_busy_out <= 1'b1;
				end
				erase_idx_reg <= erase_idx_reg + {{(FLASH_AW-1){1'b0}}, 1'b1};
			end
			default: begin
				state_reg <= ST_IDLE;
			end
			endcase
			// Page latch into buffer, placed last so a latch wins
			// over a buffer clear in the same cycle
			if (sync_rise[5] && idle && write_armed_reg) begin // R16
				if (cmd_reg == `PPI_CMD_WR_FLASH) begin
					flash_buf[word_in_page_bits] <= data_word_reg;
					flash_buf_valid[word_in_page_bits] <= 1'b1;
				end else if (cmd_reg == `PPI_CMD_WR_EEPROM) begin
					ee_buf[ee_word] <= data_word_reg[7:0];
					ee_buf_valid[ee_word] <= 1'b1;
				end
			end
		end
	end
endmodule // ppi_port

// ---- bench/ppi_port_sva.sv ----
/*
 Checker of the programming port pins, bound into ppi_port.
 Assumes BUSY_CYC is 4, so a write keeps busy low for 5 cycles.
*/
`timescale 1ns/1ps
module ppi_port_sva #(
	parameter [7:0] CAL_BYTE = 8'h7e
) (
	// Clock and reset
	input wire core_clk,
	input wire reset,
	// Watched pins
	input wire write_n,
	input wire read_enable_n,
	input wire [7:0] data_out,
	input wire data_oe,
	input wire ready_busy_out,
	input wire [7:0] rc_trim_register,
	input wire [7:0] lock_bits_out
);
	// Cycles since the write strobe was last low
	reg [3:0] wr_age_reg;
	// Saturating age count
	always @(posedge core_clk) begin
		if (reset || !write_n) wr_age_reg <= 4'h0;
		else if (wr_age_reg != 4'hf) wr_age_reg <= wr_age_reg + 4'h1;
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);
	property p_oe_idle; read_enable_n [*6] |-> !data_oe; endproperty
	a_oe_idle: assert property (p_oe_idle) else $error("bus driven while idle");
	property p_oe_rise; $rose(data_oe) |-> !read_enable_n; endproperty
	a_oe_rise: assert property (p_oe_rise) else $error("bus on without read");
	property p_out_zero; !data_oe |-> data_out == 8'h00; endproperty
	a_out_zero: assert property (p_out_zero) else $error("data seen while off");
	property p_trim_load; $fell(reset) |=> rc_trim_register == CAL_BYTE; endproperty
	a_trim_load: assert property (p_trim_load) else $error("trim not loaded");
	property p_trim_hold;
		!$past(reset) && !$past(reset, 2) |-> $stable(rc_trim_register);
	endproperty
	a_trim_hold: assert property (p_trim_hold) else $error("trim moved");
	property p_busy_min; $fell(ready_busy_out) |-> !ready_busy_out [*5]; endproperty
	a_busy_min: assert property (p_busy_min) else $error("busy too short");
	property p_busy_cause; $fell(ready_busy_out) |-> wr_age_reg < 4'h8; endproperty
	a_busy_cause: assert property (p_busy_cause) else $error("busy without strobe");
	property p_lock_chg;
		$changed(lock_bits_out) |-> !ready_busy_out || !$past(ready_busy_out);
	endproperty
	a_lock_chg: assert property (p_lock_chg) else $error("lock moved while idle");
endmodule // ppi_port_sva
bind ppi_port ppi_port_sva #(.CAL_BYTE(CAL_BYTE)) u_sva (.core_clk(core_clk), .reset(reset),
	.write_n(write_n), .read_enable_n(read_enable_n), .data_out(data_out),
	.data_oe(data_oe), .ready_busy_out(ready_busy_out),
	.rc_trim_register(rc_trim_register), .lock_bits_out(lock_bits_out));

// ---- bench/ppi_prog.sv ----
/*
 Model of the external parallel programmer.
 Assumes its tasks are entered at a falling clock edge.
*/
`timescale 1ns/1ps
module ppi_prog (
	// Clock
	input wire core_clk,
	// Device outputs
	input wire [7:0] data_out,
	input wire ready_busy_out,
	// Programmer pins
	output reg load_pulse_pin,
	output reg pulse_action_sel0,
	output reg pulse_action_sel1,
	output reg byte_sel_first,
	output reg byte_sel_second,
	output reg page_latch_pulse,
	output reg write_n,
	output reg read_enable_n,
	output reg [7:0] data_in
);
	integer busy_cnt; // Busy cycles seen on the last write
	// Entry pattern low, strobes idle
	initial begin
		{page_latch_pulse, pulse_action_sel1, pulse_action_sel0, byte_sel_first} = 4'h0;
		{load_pulse_pin, byte_sel_second, write_n, read_enable_n} = 4'h3;
		data_in = 8'h00;
		busy_cnt = 0;
	end
	// Every level held 300 ns
	task hold; repeat (6) @(negedge core_clk); endtask
	// One byte load by a load pulse
	task load(input [1:0] act, input [1:0] sel, input [7:0] b);
		{pulse_action_sel1, pulse_action_sel0} = act;
		{byte_sel_second, byte_sel_first} = sel;
		data_in = b;
		hold;
		load_pulse_pin = 1'b1;
		hold;
		load_pulse_pin = 1'b0;
		hold;
	endtask
	// Page latch pulse
	task latch; page_latch_pulse = 1'b1; hold; page_latch_pulse = 1'b0; hold; endtask
	// Write strobe low, then count busy cycles
	task wr;
		integer i;
		busy_cnt = 0;
		write_n = 1'b0;
		for (i = 0; i < 6; i = i + 1) begin
			@(negedge core_clk);
			if (!ready_busy_out) busy_cnt = busy_cnt + 1;
		end
		write_n = 1'b1;
		i = 0;
		while (!ready_busy_out && i < 20000) begin
			@(negedge core_clk);
			if (!ready_busy_out) busy_cnt = busy_cnt + 1;
			i = i + 1;
		end
		hold;
	endtask
	// Read with own bus released to a moving value
	task rd(input [1:0] sel, output [7:0] v);
		{byte_sel_second, byte_sel_first} = sel;
		data_in = ~data_in;
		read_enable_n = 1'b0;
		hold;
		v = data_out;
		read_enable_n = 1'b1;
		hold;
	endtask
endmodule // ppi_prog

// ---- bench/tb_top.sv ----
/*
 Self-checking bench of the programming port.
 Assumes the programmer model ppi_prog and a 20 MHz clock.
*/
`timescale 1ns/1ps
module tb_top;
	localparam BUSY = 4;
	// Signature and calibration values are arbitrary
	localparam [7:0] S0 = 8'h5a, S1 = 8'h3c, S2 = 8'h21, CAL = 8'h7e;
	reg core_clk = 1'b0;
	reg reset = 1'b1;
	wire lp, a0, a1, b1, b2, pl, wn, rn, oe, rdy;
	wire [7:0] din, dout, trim, lock;
	integer fail_count = 0, checks_done = 0, cyc = 0, k;
	reg [7:0] v;
	reg [31:0] rows [0:7]; // Command, address, selects, expected byte
	// Clock
	always #25 core_clk = ~core_clk;
	ppi_port #(.FLASH_AW(8), .EE_AW(6), .SIG_BYTE0(S0), .SIG_BYTE1(S1), .SIG_BYTE2(S2),
		.CAL_BYTE(CAL), .BUSY_CYC(BUSY)) u_dut (.core_clk(core_clk), .reset(reset),
		.load_pulse_pin(lp), .pulse_action_sel0(a0), .pulse_action_sel1(a1),
		.byte_sel_first(b1), .byte_sel_second(b2), .page_latch_pulse(pl), .write_n(wn),
		.read_enable_n(rn), .data_in(din), .data_out(dout), .data_oe(oe),
		.ready_busy_out(rdy), .rc_trim_register(trim), .lock_bits_out(lock));
	ppi_prog u_prog (.core_clk(core_clk), .data_out(dout), .ready_busy_out(rdy),
		.load_pulse_pin(lp), .pulse_action_sel0(a0), .pulse_action_sel1(a1),
		.byte_sel_first(b1), .byte_sel_second(b2), .page_latch_pulse(pl), .write_n(wn),
		.read_enable_n(rn), .data_in(din));
	// Compare and count
	task chk(input string name, input [7:0] seen, input [7:0] exp);
		checks_done = checks_done + 1;
		if (seen !== exp) begin
			fail_count = fail_count + 1;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// Verdict and end of run
	task end_of_test;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// Command load shortcut
	task lc(input [7:0] c); u_prog.load(2'h2, 2'h0, c); endtask
	// Hang guard
	always @(posedge core_clk) begin
		cyc = cyc + 1;
		if (cyc == 60000) begin
			fail_count = fail_count + 1;
			end_of_test;
		end
	end
	// Main sequence
	initial begin
		rows[0] = {8'h08, 8'h00, 8'h00, S0};
		rows[1] = {8'h08, 8'h01, 8'h00, S1};
		rows[2] = {8'h08, 8'h02, 8'h00, S2};
		rows[3] = {8'h08, 8'h00, 8'h01, CAL};
		rows[4] = {8'h04, 8'h00, 8'h01, 8'hff};
		rows[5] = {8'h03, 8'h06, 8'h00, 8'ha5};
		rows[6] = {8'h02, 8'h05, 8'h00, 8'h34};
		rows[7] = {8'h02, 8'h05, 8'h01, 8'h12};
		repeat (12) @(negedge core_clk);
		reset = 1'b0;
		repeat (4) @(negedge core_clk);
		chk("trim", trim, CAL);
		chk("ready", {7'h0, rdy}, 8'h01);
		chk("oe", {7'h0, oe}, 8'h00);
		lc(8'h40);
		u_prog.load(2'h1, 2'h0, 8'h6b);
		u_prog.wr;
		lc(8'h20);
		u_prog.load(2'h1, 2'h0, 8'h3c);
		u_prog.wr;
		chk("lock_wr", lock, 8'h3c);
		lc(8'h04);
		u_prog.rd(2'h0, v);
		chk("fuse_lo", v, 8'h6b);
		u_prog.rd(2'h1, v);
		chk("lock_rd", v, 8'h3c);
		lc(8'h80);
		u_prog.wr;
		chk("lock", lock, 8'hff);
		lc(8'h10);
		u_prog.load(2'h0, 2'h0, 8'h05);
		u_prog.load(2'h1, 2'h0, 8'h34);
		u_prog.load(2'h1, 2'h1, 8'h12);
		u_prog.latch;
		u_prog.load(2'h0, 2'h1, 8'h00);
		u_prog.wr;
		chk("busy", u_prog.busy_cnt[7:0], BUSY + 1);
		lc(8'h00);
		lc(8'h11);
		u_prog.load(2'h0, 2'h1, 8'h00);
		u_prog.load(2'h0, 2'h0, 8'h06);
		u_prog.load(2'h1, 2'h0, 8'ha5);
		u_prog.latch;
		u_prog.wr;
		lc(8'h00);
		for (k = 0; k < 8; k = k + 1) begin
			lc(rows[k][31:24]);
			u_prog.load(2'h0, 2'h1, 8'h00);
			u_prog.load(2'h0, 2'h0, rows[k][23:16]);
			u_prog.rd(rows[k][9:8], v);
			chk("row", v, rows[k][7:0]);
		end
		u_prog.rd(2'h0, v);
		chk("kept", v, 8'h34);
		lc(8'h55);
		u_prog.wr;
		chk("unknown", u_prog.busy_cnt[7:0], 8'h00);
		lc(8'h00);
		u_prog.wr;
		chk("nop", u_prog.busy_cnt[7:0], 8'h00);
		lc(8'h10);
		u_prog.load(2'h1, 2'h0, 8'h99);
		u_prog.latch;
		lc(8'h00);
		lc(8'h10);
		u_prog.wr;
		lc(8'h02);
		u_prog.rd(2'h0, v);
		chk("nop_clear", v, 8'h34);
		reset = 1'b1;
		repeat (3) @(negedge core_clk);
		reset = 1'b0;
		repeat (4) @(negedge core_clk);
		chk("trim2", trim, CAL);
		end_of_test;
	end
endmodule // tb_top
